// File: hdl/esc_top.sv
// Emergency stop input control with AXI4-Lite register access
// What this block does
// [R1] Stop input halts switching in hardware, trips
// [R2] Terminal 3 stop input is normally closed
// [R3] Open, broken or miswired terminal 3 trips
// [R4] Terminal 1 normally open input clears trip
// [R5] Only terminal 1 clears; panel clear ignored
// [R6] Switch on dedicates terminals 1 and 3
// [R7] Switch on sets 18/00 and 64/01, locked
// [R8] Switch on removes code 18 elsewhere
// [R9] Switch off frees settings, no restore
// [R10] Code 18 always forces polarity normally open
// [R11] Terminal 3 code 64 forces normally closed
// [R12] Panel may never write code 64 to terminal 3
// [R13] Switch off: free selection, factory defaults
// [R14] Switch on: copy refuses terminals 1,3 and flags error
// [R15] Trip stays latched; clear blocked while open
// [R16] Switch off disables the stop feature
`timescale 1ns/10ps
`default_nettype none
module esc_top
    import esc_pkg::*;
#(
    parameter int COPY_ERR_CYCLES_P = COPY_ERR_CYCLES  // Copy error display length
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Contact pins, 1 = contact closed
    input  wire logic [7:0]  terminal_in,
    input  wire logic        stop_enable_switch,
    // Output stage and status
    output logic             gate_enable,
    output logic             stop_trip_state,
    output logic [7:0]       terminal_active,
    output logic             irq,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Refuse a display timer shorter than one clock cycle
    generate
        if (COPY_ERR_CYCLES_P < 1) begin : g_bad_param
            $error("COPY_ERR_CYCLES_P must be at least one");
        end
    endgenerate

    // Address decode shared by read and write paths
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == OFS_FUNC_LO) || (a == OFS_FUNC_HI) || (a == OFS_POL) ||
                   (a == OFS_STATUS) || (a == OFS_IRQ_ST) || (a == OFS_IRQ_MASK) ||
                   (a == OFS_CP_LO) || (a == OFS_CP_HI) || (a == OFS_CP_POL);
    endfunction

    // Logical level of a contact under its polarity
    function automatic logic contact_level(input logic closed, input logic [1:0] p);
        contact_level = (p == POL_NC) ? ~closed : closed;
    endfunction

    esc_state_type s_r;    // Registered state
    esc_state_type s_nxt;  // Next state

    logic        sw_on;      // Stop feature enabled
    logic        stop_req;   // Hard stop requested now
    logic        clear_req;  // Trip clear contact active now
    logic        sw_rise;    // Switch just turned on
    logic        sw_fall;    // Switch just turned off
    logic        do_write;   // Address and data both held
    logic        is_copy;    // Write arrives on the copy port
    logic        copy_hit;   // Copy tried a locked field
    logic [2:0]  irq_ev;     // Events this cycle
    logic [2:0]  irq_clr;    // Software clear this cycle
    logic [2:0]  t_idx;      // Terminal index of a byte lane
    logic [7:0]  new_code;   // Code offered for one terminal
    logic [1:0]  new_pol;    // Polarity offered for one terminal
    logic [31:0] status_w;   // Status word

    // Live qualifiers taken from synchronised pins
    assign sw_on     = s_r.sw_sync;                                   // [R16]
    assign stop_req  = sw_on & ~s_r.term_sync[IDX_STOP];              // [R2] [R3]
    assign clear_req = s_r.term_sync[IDX_CLEAR];                      // [R4] [R5]
    assign sw_rise   = s_r.sw_sync & ~s_r.sw_prev;
    assign sw_fall   = ~s_r.sw_sync & s_r.sw_prev;
    assign do_write  = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
    assign is_copy   = (s_r.awaddr == OFS_CP_LO) || (s_r.awaddr == OFS_CP_HI) ||
                       (s_r.awaddr == OFS_CP_POL);

    // Status word seen by software
    always_comb begin
        status_w = '0;
        status_w[ST_TRIP] = s_r.trip;
        status_w[ST_SWITCH] = sw_on;
        status_w[ST_COPY_ERR] = (s_r.copy_cnt != 32'h0);
        status_w[ST_STOP_REQ] = stop_req;
        status_w[ST_ACTIVE_LSB +: 8] = s_r.active;
    end

    // Next state: pins, settings, trip, interrupts and bus
    always_comb begin
        s_nxt    = s_r;
        copy_hit = 1'b0;
        irq_clr  = '0;
        t_idx    = '0;
        new_code = '0;
        new_pol  = '0;

        // Two-stage synchronisers for pins
        s_nxt.term_meta = terminal_in;
        s_nxt.term_sync = s_r.term_meta;
        s_nxt.sw_meta   = stop_enable_switch;
        s_nxt.sw_sync   = s_r.sw_meta;
        s_nxt.sw_prev   = s_r.sw_sync;

        // Logical level of every input
        for (int k = 0; k < 8; k++) begin
            s_nxt.active[k] = contact_level(s_r.term_sync[k], s_r.pol[k]);
        end

        // Write channels: take address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end

        // Register write once both halves are held
        if (do_write) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = addr_hit(s_r.awaddr) ? RESP_OKAY : RESP_DECERR;
            unique case (s_r.awaddr)
                // Function codes, one byte lane per terminal
                OFS_FUNC_LO, OFS_FUNC_HI, OFS_CP_LO, OFS_CP_HI: begin
                    for (int b = 0; b < 4; b++) begin
                        t_idx = ((s_r.awaddr == OFS_FUNC_HI) || (s_r.awaddr == OFS_CP_HI))
                              ? 3'(b + 4) : 3'(b);
                        new_code = s_r.wdata[b*8 +: 8];
                        if (s_r.wstrb[b]) begin
                            if (sw_on && (t_idx == 3'(IDX_CLEAR) || t_idx == 3'(IDX_STOP))) begin
                                copy_hit = is_copy;                       // [R6] [R7] [R14]
                            end else if (t_idx == 3'(IDX_STOP) && new_code == FN_STOP) begin
                                s_nxt.func[t_idx] = s_r.func[t_idx];      // [R12]
                            end else if (sw_on && new_code == FN_CLEAR) begin
                                s_nxt.func[t_idx] = s_r.func[t_idx];      // [R8]
                            end else begin
                                s_nxt.func[t_idx] = new_code;             // [R13]
                            end
                        end
                    end
                end
                // Polarity, two bits per terminal in the low half word
                OFS_POL, OFS_CP_POL: begin
                    for (int k = 0; k < 8; k++) begin
                        new_pol = s_r.wdata[k*2 +: 2];
                        if (s_r.wstrb[k/4]) begin
                            if (sw_on && (k == IDX_CLEAR || k == IDX_STOP)) begin
                                copy_hit = copy_hit | is_copy;            // [R7] [R14]
                            end else begin
                                s_nxt.pol[k] = new_pol;                   // [R13]
                            end
                        end
                    end
                end
                // Write one to clear sticky events
                OFS_IRQ_ST: begin
                    if (s_r.wstrb[0]) begin
                        irq_clr = s_r.wdata[2:0];
                    end
                end
                // Interrupt enables
                OFS_IRQ_MASK: begin
                    if (s_r.wstrb[0]) begin
                        s_nxt.irq_mask = s_r.wdata[2:0];
                    end
                end
                // Status and unmapped: no storage
                default: begin
                end
            endcase
        end

        // Write response leaves on bready
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Read: latch data on address handshake
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
            unique case (s_axi_araddr)
                OFS_FUNC_LO, OFS_CP_LO: s_nxt.rdata = {s_r.func[3], s_r.func[2],
                                                       s_r.func[1], s_r.func[0]};
                OFS_FUNC_HI, OFS_CP_HI: s_nxt.rdata = {s_r.func[7], s_r.func[6],
                                                       s_r.func[5], s_r.func[4]};
                OFS_POL, OFS_CP_POL:    s_nxt.rdata = {16'h0000, s_r.pol};
                OFS_STATUS:             s_nxt.rdata = status_w;
                OFS_IRQ_ST:             s_nxt.rdata = {29'h0, s_r.irq_st};
                OFS_IRQ_MASK:           s_nxt.rdata = {29'h0, s_r.irq_mask};
                default:                s_nxt.rdata = 32'h0;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // Switch turned on: claim terminals 1 and 3
        if (sw_rise) begin
            for (int k = 0; k < 8; k++) begin
                if (s_nxt.func[k] == FN_CLEAR) begin
                    s_nxt.func[k] = FN_NONE;                              // [R8]
                end
            end
            s_nxt.func[IDX_CLEAR] = FN_CLEAR;                             // [R6] [R7]
            s_nxt.pol[IDX_CLEAR]  = POL_NO;                               // [R7]
            s_nxt.func[IDX_STOP]  = FN_STOP;                              // [R6] [R7]
            s_nxt.pol[IDX_STOP]   = POL_NC;                               // [R7]
        end

        // Switch turned off: release terminal 3, keep the rest as is
        if (sw_fall) begin
            s_nxt.func[IDX_STOP] = FN_NONE;                               // [R9]
        end

        // Polarity forcing applied after every change
        for (int k = 0; k < 8; k++) begin
            if (s_nxt.func[k] == FN_CLEAR) begin
                s_nxt.pol[k] = POL_NO;                                    // [R10]
            end
        end
        if (s_nxt.func[IDX_STOP] == FN_STOP) begin
            s_nxt.pol[IDX_STOP] = POL_NC;                                 // [R11]
        end

        // Latched trip: stop sets, terminal 1 clears only once stop recloses
        if (stop_req) begin
            s_nxt.trip = 1'b1;                                            // [R1] [R3] [R15]
        end else if (clear_req) begin
            s_nxt.trip = 1'b0;                                            // [R4] [R5] [R15]
        end

        // Copy error display timer
        if (copy_hit) begin
            s_nxt.copy_cnt = 32'(COPY_ERR_CYCLES_P);                      // [R14]
        end else if (s_r.copy_cnt != 32'h0) begin
            s_nxt.copy_cnt = s_r.copy_cnt - 32'h1;
        end

        // Sticky events: a new event wins over a clear
        irq_ev = '0;
        irq_ev[IRQ_TRIP]   = stop_req & ~s_r.trip;
        irq_ev[IRQ_COPY]   = copy_hit;
        irq_ev[IRQ_SWITCH] = sw_rise | sw_fall;
        s_nxt.irq_st = (s_r.irq_st & ~irq_clr) | irq_ev;

        // Synchronous reset to factory state
        if (!aresetn) begin
            s_nxt      = '0;
            s_nxt.func = FUNC_RST;                                        // [R13]
            s_nxt.pol  = POL_RST;                                         // [R13]
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    // Output stage gating goes straight from the synchronised pin
    assign gate_enable     = ~(s_r.trip | stop_req);                      // [R1]
    assign stop_trip_state = s_r.trip;
    assign terminal_active = s_r.active;
    assign irq             = |(s_r.irq_st & s_r.irq_mask);

    // Bus handshake outputs
    assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid;
    assign s_axi_wready  = ~s_r.w_got & ~s_r.bvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = ~s_r.rvalid;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;

endmodule
`default_nettype wire

// File: hdl/esc_pkg.sv
// Package: constants and state type of the emergency stop input control
package esc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FUNC_LO   = 8'h00; // Function codes, inputs 1 to 4
    localparam logic [7:0] OFS_FUNC_HI   = 8'h04; // Function codes, inputs 5 to 8
    localparam logic [7:0] OFS_POL       = 8'h08; // Polarity, 2 bits per input
    localparam logic [7:0] OFS_STATUS    = 8'h0C; // Live state, read only
    localparam logic [7:0] OFS_IRQ_ST    = 8'h10; // Sticky events, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14; // Interrupt enables
    localparam logic [7:0] OFS_CP_LO     = 8'h20; // Copy port, function codes 1 to 4
    localparam logic [7:0] OFS_CP_HI     = 8'h24; // Copy port, function codes 5 to 8
    localparam logic [7:0] OFS_CP_POL    = 8'h28; // Copy port, polarity
    // Function codes
    localparam logic [7:0] FN_CLEAR      = 8'h12; // Trip clear input (18)
    localparam logic [7:0] FN_JOG        = 8'h06; // Jog function (06)
    localparam logic [7:0] FN_STOP       = 8'h40; // Hard stop input (64)
    localparam logic [7:0] FN_NONE       = 8'hFF; // No function assigned
    // Polarity codes
    localparam logic [1:0] POL_NO        = 2'h0;  // Normally open
    localparam logic [1:0] POL_NC        = 2'h1;  // Normally closed
    // Terminal indices (terminal n sits at index n-1)
    localparam int         IDX_CLEAR     = 0;
    localparam int         IDX_STOP      = 2;
    // Status bit positions
    localparam int         ST_TRIP       = 0;
    localparam int         ST_SWITCH     = 1;
    localparam int         ST_COPY_ERR   = 2;
    localparam int         ST_STOP_REQ   = 3;
    localparam int         ST_ACTIVE_LSB = 8;
    // Interrupt bit positions
    localparam int         IRQ_TRIP      = 0;
    localparam int         IRQ_COPY      = 1;
    localparam int         IRQ_SWITCH    = 2;
    // Reset values
    localparam logic [7:0][7:0] FUNC_RST = {FN_NONE, FN_NONE, FN_NONE, FN_NONE,
                                            FN_NONE, FN_JOG, FN_NONE, FN_CLEAR};
    localparam logic [7:0][1:0] POL_RST  = '0;
    // Timing
    localparam int         CLK_PERIOD_NS   = 10;        // 100 MHz
    localparam int         COPY_ERR_TIME_NS = 1000000;  // Copy error display, 1 ms
    localparam int         COPY_ERR_CYCLES = COPY_ERR_TIME_NS / CLK_PERIOD_NS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_DECERR   = 2'h3;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]       term_meta;  // Terminal synchroniser, first stage
        logic [7:0]       term_sync;  // Terminal synchroniser, second stage
        logic             sw_meta;    // Switch synchroniser, first stage
        logic             sw_sync;    // Switch synchroniser, second stage
        logic             sw_prev;    // Switch level one cycle back
        logic [7:0][7:0]  func;       // Function code per input
        logic [7:0][1:0]  pol;        // Polarity per input
        logic             trip;       // Latched stop trip
        logic [7:0]       active;     // Logical level per input
        logic [2:0]       irq_st;     // Sticky events
        logic [2:0]       irq_mask;   // Event enables
        logic [31:0]      copy_cnt;   // Copy error display timer
        logic             aw_got;     // Write address held
        logic [7:0]       awaddr;     // Held write address
        logic             w_got;      // Write data held
        logic [31:0]      wdata;      // Held write data
        logic [3:0]       wstrb;      // Held byte enables
        logic             bvalid;     // Write response pending
        logic [1:0]       bresp;      // Write response code
        logic             rvalid;     // Read data pending
        logic [31:0]      rdata;      // Read data
        logic [1:0]       rresp;      // Read response code
    } esc_state_type;
endpackage

// File: verification/esc_safety_model.sv
// Partner: external safety circuit wired to the contact pins
`timescale 1ns/10ps
`default_nettype none
module esc_safety_model (
    input  wire logic       aclk,
    input  wire logic       stop_open,
    input  wire logic       clear_press,
    input  wire logic       switch_on,
    output var logic [7:0]  terminal_in,
    output var logic        stop_enable_switch
);
    // Closed stop chain, open clear button, switch off
    initial begin
        terminal_in = 8'h04;
        stop_enable_switch = 1'b0;
    end
    // Contacts move just after an edge; unused inputs left open
    always @(posedge aclk) begin
        terminal_in <= {5'h00, !stop_open, 1'b0, clear_press};
        stop_enable_switch <= switch_on;
    end
endmodule
`default_nettype wire

// File: verification/esc_assertions.sv
// Checker: port-level properties of the stop control
`timescale 1ns/10ps
`default_nettype none
module esc_assertions
    import esc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  terminal_in,
    input wire logic        stop_enable_switch,
    input wire logic        gate_enable,
    input wire logic        stop_trip_state,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_trip_gate_off: assert property (stop_trip_state |-> !gate_enable)
        else $error("gate enabled while tripped");
    a_open_stops: assert property ((stop_enable_switch && !terminal_in[2]) [*8]
        |-> !gate_enable) else $error("open stop chain left gate on");
    a_rise_cause: assert property ($rose(stop_trip_state) |-> !$past(terminal_in[2], 3))
        else $error("trip without open stop chain");
    a_fall_cause: assert property ($fell(stop_trip_state) && $past(aresetn)
        |-> $past(terminal_in[0], 3)) else $error("trip released without clear pin");
    a_switch_off_run: assert property ((!stop_enable_switch && !stop_trip_state) [*8]
        |-> gate_enable) else $error("gate off with feature disabled");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during pending read");
    a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h30
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered wrongly");
    c_trip: cover property ($rose(stop_trip_state));
    c_clear: cover property ($fell(stop_trip_state));
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule
bind esc_top esc_assertions u_chk (.aclk, .aresetn, .terminal_in, .stop_enable_switch,
    .gate_enable, .stop_trip_state, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// File: verification/esc_tb_top.sv
// Testbench: register rows, then trip and switch sequences
`timescale 1ns/10ps
`default_nettype none
module esc_tb_top
    import esc_pkg::*;
;
    logic        aclk, aresetn, stop_enable_switch, gate_enable, stop_trip_state, irq;
    logic [7:0]  terminal_in, terminal_active, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, g;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        stop_open, clear_press, switch_on;
    int          fail_count, comparisons;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} esc_row_type;
    // Address, write data, read-back, response; switch off
    esc_row_type rows [5] = '{'{8'h00, 32'hFF061212, 32'hFF061212, RESP_OKAY},
        '{8'h08, 32'h00000005, 32'h00000000, RESP_OKAY},
        '{8'h00, 32'hFF401212, 32'hFF061212, RESP_OKAY},
        '{8'h08, 32'h00000010, 32'h00000010, RESP_OKAY},
        '{8'h30, 32'h12345678, 32'h00000000, RESP_DECERR}};
    esc_top #(.COPY_ERR_CYCLES_P(16)) dut (.aclk, .aresetn, .terminal_in, .stop_enable_switch,
        .gate_enable, .stop_trip_state, .terminal_active, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    esc_safety_model u_far (.aclk, .stop_open, .clear_press, .switch_on, .terminal_in,
        .stop_enable_switch);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic complete_run();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic hang(input string n);
        chk(n, 32'h1, 32'h0);
        complete_run();
    endtask
    // Write both halves together, drop each when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write_done");
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                rs = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read_done");
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a, g, r);
        chk("rdata", e, g);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, e, input logic [1:0] re);
        axi_wr(a, d, r);
        chk("bresp", {30'h0, re}, {30'h0, r});
        axi_rd(a, g, r);
        chk("rdata", e, g);
        chk("rresp", {30'h0, re}, {30'h0, r});
    endtask
    task automatic wait_trip(input logic e);
        for (int n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (stop_trip_state === e) return;
        end
        hang("trip_level");
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, stop_open, clear_press, switch_on} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        fail_count = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFS_FUNC_LO, 32'hFF06FF12);
        chk("gate", 1, gate_enable);
        foreach (rows[i]) wr_rd(rows[i].a, rows[i].d, rows[i].e, rows[i].r);
        switch_on <= 1'b1;
        repeat (10) @(posedge aclk);
        rd_chk(OFS_FUNC_LO, 32'hFF40FF12);
        wr_rd(OFS_FUNC_LO, 32'hFF060606, 32'hFF400612, RESP_OKAY);
        wr_rd(OFS_POL, 32'h0, 32'h10, RESP_OKAY);
        axi_wr(OFS_CP_LO, 32'h06060606, r);
        chk("irq", 0, irq);
        axi_rd(OFS_STATUS, g, r);
        chk("copy_err", 1, {31'h0, g[ST_COPY_ERR]});
        rd_chk(OFS_FUNC_LO, 32'h06400612);
        axi_wr(OFS_IRQ_MASK, 32'h2, r);
        chk("irq", 1, irq);
        axi_wr(OFS_IRQ_ST, 32'h2, r);
        chk("irq", 0, irq);
        axi_rd(OFS_STATUS, g, r);
        chk("copy_err", 0, {31'h0, g[ST_COPY_ERR]});
        stop_open <= 1'b1;
        wait_trip(1'b1);
        chk("gate", 0, gate_enable);
        stop_open <= 1'b0;
        axi_wr(OFS_IRQ_ST, 32'h1, r);
        repeat (10) @(posedge aclk);
        chk("trip", 1, stop_trip_state);
        stop_open <= 1'b1;
        clear_press <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("trip", 1, stop_trip_state);
        stop_open <= 1'b0;
        wait_trip(1'b0);
        clear_press <= 1'b0;
        switch_on <= 1'b0;
        repeat (10) @(posedge aclk);
        rd_chk(OFS_FUNC_LO, 32'h06FF0612);
        rd_chk(OFS_POL, 32'h10);
        stop_open <= 1'b1;
        repeat (10) @(posedge aclk);
        chk("trip", 0, stop_trip_state);
        chk("gate", 1, gate_enable);
        chk("active", 32'h04, {24'h0, terminal_active});
        complete_run();
    end
endmodule
`default_nettype wire
